// ===== ssrx_sequencer.sv
// Receive sequencer of the spread-spectrum modem with its register slave.
//
// What this block does
// - Search window resets to 5 symbols; software keeps it within 4 to 1023.
// - Single-shot: no preamble by window end sets timeout flag, goes standby.
// - Payload end sets packet flag, plus check-fail flag on bad CRC.
// - Every payload byte is stored, even when the CRC fails.
// - Single-shot leaves receive for standby after packet or timeout flag.
// - Single-shot drops synthesizer and RF enables once a packet is done.
// - Preamble found fixes gain; valid header raises header flag first.
// - Continuous mode resumes preamble search after each packet.
// - Overlong preamble is dropped and search restarts without any flag.
// - Continuous timeout sets only the flag; reception continues.
// - Continuous packets are written back to back; write pointer not reset.
// - Per-packet status holds only the latest packet, overwritten each time.
// - Live next-write address is one past the last byte written.
// - Header flag is also raised in implicit-header operation.
// - Timeout timer starts when the buffer clear that follows entry to a receive mode ends.
// - Timeout lasts the programmed count times the symbol period.
// - Each data port access advances the buffer pointer by one.
// - Buffer clears on entry to receive and is inaccessible in sleep.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ssrx_sequencer
  import ssrx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Demodulator events, same clock domain.
  input wire logic dem_symbol_en,
  input wire logic dem_preamble_sym,
  input wire logic dem_preamble_lock,
  input wire logic dem_header_ok,
  input wire logic dem_byte_valid,
  input wire logic [7:0] dem_byte,
  input wire logic dem_payload_end,
  input wire logic dem_crc_ok,
  // Analog and modem control.
  output logic synth_enable,
  output logic rf_rx_enable,
  output logic gain_freeze,
  output logic search_restart
);

  // ********************************************************************
  // State record.
  // ********************************************************************
  typedef struct packed {
    ssrx_mode_t mode;
    ssrx_state_t state;
    logic [9:0] window;
    logic [15:0] preamble_len;
    logic [15:0] timeout_cnt;
    logic [15:0] symdiv;
    logic implicit_hdr;
    logic [3:0] flags;
    logic [7:0] access_ptr;
    logic [7:0] rx_base;
    logic [7:0] tx_base;
    logic [7:0] write_pos;
    logic [7:0] last_start;
    logic [7:0] last_count;
    logic [8:0] clear_idx;
    logic [15:0] div_cnt;
    logic [15:0] sym_cnt;
    logic [15:0] pre_cnt;
    logic timeout_armed;
    logic [7:0] cur_count;
    logic gain;
    logic restart;
    logic [1:0] rd_phase;
    logic [31:0] rdata;
  } ssrx_regs_t;

  ssrx_regs_t r_reg;
  ssrx_regs_t r_next;

  logic buf_wr;
  logic [7:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic [7:0] buf_raddr;
  logic [7:0] buf_rdata;
  logic rx_busy;

  // ********************************************************************
  // Helpers.
  // ********************************************************************
  function automatic logic is_rx(input ssrx_mode_t m);
    return (m == SSRX_MODE_SINGLE) || (m == SSRX_MODE_CONT);
  endfunction : is_rx

  function automatic logic [7:0] inc8(input logic [7:0] v);
    return v + 8'h01;
  endfunction : inc8

  ssrx_buffer #(.DEPTH(256), .AW(8)) u_buf (
    .clk(clk),
    .wr_en(buf_wr),
    .wr_addr(buf_waddr),
    .wr_data(buf_wdata),
    .rd_addr(buf_raddr),
    .rd_data(buf_rdata)
  );

  // ********************************************************************
  // Next-state logic.
  // ********************************************************************
  always_comb begin
    logic data_rd;
    logic sym_tick;
    logic in_rx;
    logic stop_rx;
    logic cfg_ok;
    data_rd = 1'b0;
    sym_tick = 1'b0;
    in_rx = 1'b0;
    stop_rx = 1'b0;
    cfg_ok = 1'b0;
    r_next = r_reg;
    r_next.restart = 1'b0;
    buf_wr = 1'b0;
    buf_waddr = r_reg.write_pos;
    buf_wdata = dem_byte;
    buf_raddr = r_reg.access_ptr;
    in_rx = is_rx(r_reg.mode) && (r_reg.state != SSRX_ST_IDLE)
            && (r_reg.state != SSRX_ST_CLEAR);
    cfg_ok = !(in_rx && (r_reg.state != SSRX_ST_SEARCH));

    // Symbol divider for the timeout timer.
    if (in_rx) begin
      if (r_reg.div_cnt + 16'h0001 >= r_reg.symdiv) begin
        r_next.div_cnt = 16'h0000;
        sym_tick = 1'b1;
      end else begin
        r_next.div_cnt = r_reg.div_cnt + 16'h0001;
      end
    end

    // Sequencer.
    unique case (r_reg.state)
      SSRX_ST_IDLE: begin
        r_next.gain = 1'b0;
      end
      SSRX_ST_CLEAR: begin
        buf_wr = 1'b1;
        buf_waddr = r_reg.clear_idx[7:0];
        buf_wdata = 8'h00;
        if (r_reg.clear_idx == SSRX_CLEAR_LAST) begin
          r_next.state = SSRX_ST_SEARCH;
          r_next.sym_cnt = 16'h0000;
          r_next.div_cnt = 16'h0000;
          r_next.pre_cnt = 16'h0000;
          r_next.timeout_armed = 1'b1;
        end else begin
          r_next.clear_idx = r_reg.clear_idx + 9'h001;
        end
      end
      SSRX_ST_SEARCH: begin
        if (dem_preamble_lock) begin
          r_next.gain = 1'b1;
          r_next.state = SSRX_ST_HEADER;
        end else if (dem_symbol_en && dem_preamble_sym) begin
          if (r_reg.pre_cnt + 16'h0001 > r_reg.preamble_len) begin
            r_next.pre_cnt = 16'h0000;
            r_next.restart = 1'b1;
          end else begin
            r_next.pre_cnt = r_reg.pre_cnt + 16'h0001;
          end
        end
      end
      SSRX_ST_HEADER: begin
        if (dem_header_ok) begin
          r_next.flags[SSRX_FLAG_HEADER] = 1'b1;
          r_next.cur_count = 8'h00;
          r_next.last_start = r_reg.write_pos;
          r_next.state = SSRX_ST_PAYLOAD;
        end
      end
      SSRX_ST_PAYLOAD: begin
        if (dem_byte_valid) begin
          buf_wr = 1'b1;
          r_next.write_pos = inc8(r_reg.write_pos);
          r_next.cur_count = inc8(r_reg.cur_count);
        end
        if (dem_payload_end) begin
          r_next.flags[SSRX_FLAG_PACKET_RECEIVED_FLAG] = 1'b1;
          if (!dem_crc_ok) begin
            r_next.flags[SSRX_FLAG_CRCFAIL] = 1'b1;
          end
          r_next.last_count = dem_byte_valid ? inc8(r_reg.cur_count)
                                             : r_reg.cur_count;
          r_next.gain = 1'b0;
          r_next.pre_cnt = 16'h0000;
          if (r_reg.mode == SSRX_MODE_SINGLE) begin
            stop_rx = 1'b1;
          end else begin
            r_next.state = SSRX_ST_SEARCH;
          end
        end
      end
      default: r_next.state = SSRX_ST_IDLE;
    endcase

    // Receive timeout counted in symbols.
    if (in_rx && sym_tick && r_reg.timeout_armed) begin
      r_next.sym_cnt = r_reg.sym_cnt + 16'h0001;
      if ((r_reg.mode == SSRX_MODE_SINGLE && r_reg.state == SSRX_ST_SEARCH
           && r_reg.sym_cnt + 16'h0001 >= {6'h00, r_reg.window})
          || (r_reg.timeout_cnt != 16'h0000
              && r_reg.sym_cnt + 16'h0001 >= r_reg.timeout_cnt)) begin
        r_next.flags[SSRX_FLAG_TIMEOUT] = 1'b1;
        r_next.timeout_armed = 1'b0;
        if (r_reg.mode == SSRX_MODE_SINGLE) begin
          stop_rx = 1'b1;
        end
      end
    end
    if (stop_rx) begin
      r_next.mode = SSRX_MODE_STANDBY;
      r_next.state = SSRX_ST_IDLE;
      r_next.gain = 1'b0;
    end

    // Register slave; a read is stalled for two cycles for the buffer latency.
    r_next.rd_phase = 2'b00;
    if (avs_read && r_reg.rd_phase == 2'b00) begin
      r_next.rd_phase = 2'b01;
    end else if (avs_read && r_reg.rd_phase == 2'b01) begin
      r_next.rd_phase = 2'b10;
      r_next.rdata = 32'h0000_0000;
      unique case (avs_address)
        SSRX_ADDR_MODE: r_next.rdata = {29'h0, r_reg.mode};
        SSRX_ADDR_WINDOW: r_next.rdata = {22'h0, r_reg.window};
        SSRX_ADDR_PREAMBLE: r_next.rdata = {16'h0, r_reg.preamble_len};
        SSRX_ADDR_TIMEOUT: r_next.rdata = {16'h0, r_reg.timeout_cnt};
        SSRX_ADDR_FLAGS: r_next.rdata = {28'h0, r_reg.flags};
        SSRX_ADDR_PTR: r_next.rdata = {24'h0, r_reg.access_ptr};
        SSRX_ADDR_DATA: begin
          if (r_reg.mode != SSRX_MODE_SLEEP) begin
            r_next.rdata = {24'h0, buf_rdata};
            data_rd = 1'b1;
          end
        end
        SSRX_ADDR_BASES: r_next.rdata = {16'h0, r_reg.tx_base, r_reg.rx_base};
        SSRX_ADDR_RXSTAT: r_next.rdata = {8'h0, r_reg.write_pos,
                                          r_reg.last_count,
                                          r_reg.last_start};
        SSRX_ADDR_SYMDIV: r_next.rdata = {16'h0, r_reg.symdiv};
        SSRX_ADDR_HDRMODE: r_next.rdata = {31'h0, r_reg.implicit_hdr};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (data_rd) begin
      r_next.access_ptr = inc8(r_reg.access_ptr);
    end

    // The receiver owns the buffer write port in this cycle.
    rx_busy = buf_wr;
    if (avs_write) begin
      unique case (avs_address)
        SSRX_ADDR_MODE: begin
          if (avs_writedata[2:0] == SSRX_MODE_SLEEP
              || avs_writedata[2:0] == SSRX_MODE_STANDBY
              || avs_writedata[2:0] == SSRX_MODE_SYNTH
              || avs_writedata[2:0] == SSRX_MODE_CONT
              || avs_writedata[2:0] == SSRX_MODE_SINGLE) begin
            r_next.mode = ssrx_mode_t'(avs_writedata[2:0]);
            if (is_rx(ssrx_mode_t'(avs_writedata[2:0]))
                && ssrx_mode_t'(avs_writedata[2:0]) != r_reg.mode) begin
              r_next.state = SSRX_ST_CLEAR;
              r_next.clear_idx = 9'h000;
              r_next.write_pos = r_reg.rx_base;
              r_next.timeout_armed = 1'b0;
            end else if (!is_rx(ssrx_mode_t'(avs_writedata[2:0]))) begin
              r_next.state = SSRX_ST_IDLE;
              r_next.gain = 1'b0;
            end
          end
        end
        SSRX_ADDR_WINDOW: if (cfg_ok) r_next.window = avs_writedata[9:0];
        SSRX_ADDR_PREAMBLE: begin
          if (cfg_ok) r_next.preamble_len = avs_writedata[15:0];
        end
        SSRX_ADDR_TIMEOUT: begin
          if (cfg_ok) r_next.timeout_cnt = avs_writedata[15:0];
        end
        SSRX_ADDR_FLAGS: begin
          r_next.flags = r_next.flags & ~(avs_writedata[3:0]
                                          & ~(r_next.flags ^ r_reg.flags));
        end
        SSRX_ADDR_PTR: r_next.access_ptr = avs_writedata[7:0];
        SSRX_ADDR_DATA: begin
          if (r_reg.mode != SSRX_MODE_SLEEP && !rx_busy) begin
            buf_wr = 1'b1;
            buf_waddr = r_reg.access_ptr;
            buf_wdata = avs_writedata[7:0];
            r_next.access_ptr = inc8(r_reg.access_ptr);
          end
        end
        SSRX_ADDR_BASES: begin
          if (cfg_ok) begin
            r_next.rx_base = avs_writedata[7:0];
            r_next.tx_base = avs_writedata[15:8];
          end
        end
        SSRX_ADDR_SYMDIV: if (cfg_ok) r_next.symdiv = avs_writedata[15:0];
        SSRX_ADDR_HDRMODE: if (cfg_ok) r_next.implicit_hdr = avs_writedata[0];
        default: r_next.rdata = r_reg.rdata;
      endcase
    end
  end

  // ********************************************************************
  // Register.
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.mode <= SSRX_MODE_SLEEP;
      r_reg.state <= SSRX_ST_IDLE;
      r_reg.window <= SSRX_WINDOW_RST;
      r_reg.preamble_len <= SSRX_PREAMBLE_RST;
      r_reg.timeout_cnt <= SSRX_TIMEOUT_RST;
      r_reg.symdiv <= SSRX_SYMDIV_RST;
      r_reg.rx_base <= SSRX_RXBASE_RST;
      r_reg.tx_base <= SSRX_TXBASE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ********************************************************************
  // Outputs.
  // ********************************************************************
  assign avs_waitrequest = (avs_read && r_reg.rd_phase != 2'b10)
                           || (avs_write && rx_busy
                               && avs_address == SSRX_ADDR_DATA
                               && r_reg.mode != SSRX_MODE_SLEEP);
  assign avs_readdata = r_reg.rdata;
  assign synth_enable = is_rx(r_reg.mode) || r_reg.mode == SSRX_MODE_SYNTH;
  assign rf_rx_enable = is_rx(r_reg.mode);
  assign gain_freeze = r_reg.gain;
  assign search_restart = r_reg.restart;

endmodule : ssrx_sequencer
`default_nettype wire

// ===== ssrx_pkg.sv
// Package of constants and types for the receive sequencer.
package ssrx_pkg;

  // ********************************************************************
  // Register map (byte addresses, word aligned).
  // ********************************************************************
  localparam logic [7:0] SSRX_ADDR_MODE = 8'h00;
  localparam logic [7:0] SSRX_ADDR_WINDOW = 8'h04;
  localparam logic [7:0] SSRX_ADDR_PREAMBLE = 8'h08;
  localparam logic [7:0] SSRX_ADDR_TIMEOUT = 8'h0c;
  localparam logic [7:0] SSRX_ADDR_FLAGS = 8'h10;
  localparam logic [7:0] SSRX_ADDR_PTR = 8'h14;
  localparam logic [7:0] SSRX_ADDR_DATA = 8'h18;
  localparam logic [7:0] SSRX_ADDR_BASES = 8'h1c;
  localparam logic [7:0] SSRX_ADDR_RXSTAT = 8'h20;
  localparam logic [7:0] SSRX_ADDR_SYMDIV = 8'h24;
  localparam logic [7:0] SSRX_ADDR_HDRMODE = 8'h28;

  // ********************************************************************
  // Field positions of the flag register.
  // ********************************************************************
  localparam int SSRX_FLAG_TIMEOUT = 0;
  localparam int SSRX_FLAG_PACKET_RECEIVED_FLAG = 1;
  localparam int SSRX_FLAG_CRCFAIL = 2;
  localparam int SSRX_FLAG_HEADER = 3;

  // ********************************************************************
  // Reset values and the last index of the buffer clear.
  // ********************************************************************
  localparam logic [9:0] SSRX_WINDOW_RST = 10'h005;
  localparam logic [15:0] SSRX_PREAMBLE_RST = 16'h0008;
  localparam logic [15:0] SSRX_TIMEOUT_RST = 16'h0000;
  localparam logic [7:0] SSRX_RXBASE_RST = 8'h00;
  localparam logic [7:0] SSRX_TXBASE_RST = 8'h80;
  localparam logic [15:0] SSRX_SYMDIV_RST = 16'h0028;
  localparam logic [8:0] SSRX_CLEAR_LAST = 9'h0ff;

  // ********************************************************************
  // Operating modes and sequencer states.
  // ********************************************************************
  typedef enum logic [2:0] {
    SSRX_MODE_SLEEP = 3'h0,
    SSRX_MODE_STANDBY = 3'h1,
    SSRX_MODE_SYNTH = 3'h4,
    SSRX_MODE_CONT = 3'h5,
    SSRX_MODE_SINGLE = 3'h6
  } ssrx_mode_t;

  typedef enum logic [2:0] {
    SSRX_ST_IDLE = 3'b000,
    SSRX_ST_CLEAR = 3'b001,
    SSRX_ST_SEARCH = 3'b011,
    SSRX_ST_HEADER = 3'b010,
    SSRX_ST_PAYLOAD = 3'b110
  } ssrx_state_t;

endpackage : ssrx_pkg

// ===== ssrx_buffer.sv
// Packet buffer memory with one write port and one read port.
`timescale 1ns/1ps
`default_nettype none
module ssrx_buffer
  import ssrx_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock.
  input wire logic clk,
  // Write side.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read side.
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : ssrx_buffer
`default_nettype wire

// ===== ssrx_host_model.sv
// Host controller model that masters the register bus.
`timescale 1ns/1ps
`default_nettype none
module ssrx_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Command side.
  input wire logic go,
  input wire logic go_wr,
  input wire logic [7:0] go_addr,
  input wire logic [31:0] go_data,
  output logic done,
  output logic [31:0] rdata,
  // Avalon-MM master.
  output logic [7:0] avm_address,
  output logic avm_read,
  output logic avm_write,
  output logic [31:0] avm_writedata,
  input wire logic [31:0] avm_readdata,
  input wire logic avm_waitrequest
);
  // Holds each request until waitrequest is seen low, then releases it.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      avm_read <= 1'b0;
      avm_write <= 1'b0;
      avm_address <= 8'h00;
      avm_writedata <= 32'h0;
      rdata <= 32'h0;
    end else if (go && !avm_read && !avm_write) begin
      avm_address <= go_addr;
      avm_read <= !go_wr;
      avm_write <= go_wr;
      avm_writedata <= go_data;
    end else if ((avm_read || avm_write) && !avm_waitrequest) begin
      if (avm_read) begin
        rdata <= avm_readdata;
      end
      avm_read <= 1'b0;
      avm_write <= 1'b0;
      avm_writedata <= ~avm_writedata;
      done <= 1'b1;
    end
  end
endmodule : ssrx_host_model
`default_nettype wire

// ===== ssrx_sequencer_asserts.sv
// Checker of port relations of the receive sequencer.
`timescale 1ns/1ps
`default_nettype none
module ssrx_sequencer_asserts
  import ssrx_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Demodulator events.
  input wire logic dem_symbol_en,
  input wire logic dem_preamble_sym,
  input wire logic dem_preamble_lock,
  input wire logic dem_header_ok,
  input wire logic dem_byte_valid,
  input wire logic [7:0] dem_byte,
  input wire logic dem_payload_end,
  input wire logic dem_crc_ok,
  // Control outputs.
  input wire logic synth_enable,
  input wire logic rf_rx_enable,
  input wire logic gain_freeze,
  input wire logic search_restart
);
  logic [2:0] mode_trk;
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_trk <= SSRX_MODE_SLEEP;
    end else if (avs_write && !avs_waitrequest &&
                 avs_address == SSRX_ADDR_MODE) begin
      mode_trk <= avs_writedata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_wr_fast;
    avs_write && avs_address != SSRX_ADDR_DATA |-> !avs_waitrequest;
  endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_wr_stall;
    avs_write && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall long");
  property p_rd_lat;
    $rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest
      ##1 !avs_waitrequest;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
  property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_sleep;
    mode_trk == SSRX_MODE_SLEEP |-> !synth_enable && !rf_rx_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("enable in sleep");
  property p_gain;
    $rose(gain_freeze) |-> $past(dem_preamble_lock);
  endproperty
  a_gain: assert property (p_gain) else $error("gain fixed early");
  property p_restart;
    search_restart |-> !gain_freeze ##1 !search_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
  property p_single_end;
    mode_trk == SSRX_MODE_SINGLE && gain_freeze && dem_payload_end
      |-> ##[1:3] !rf_rx_enable && !synth_enable;
  endproperty
  a_single_end: assert property (p_single_end) else $error("no standby");
  property p_cont_end;
    mode_trk == SSRX_MODE_CONT && gain_freeze && dem_payload_end
      |=> rf_rx_enable [*4];
  endproperty
  a_cont_end: assert property (p_cont_end) else $error("left cont");
  property p_exit;
    $fell(rf_rx_enable) |=> !gain_freeze;
  endproperty
  a_exit: assert property (p_exit) else $error("gain still fixed");
endmodule : ssrx_sequencer_asserts
bind ssrx_sequencer ssrx_sequencer_asserts u_ssrx_sequencer_asserts (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .dem_symbol_en(dem_symbol_en), .dem_preamble_sym(dem_preamble_sym),
  .dem_preamble_lock(dem_preamble_lock), .dem_header_ok(dem_header_ok),
  .dem_byte_valid(dem_byte_valid), .dem_byte(dem_byte),
  .dem_payload_end(dem_payload_end), .dem_crc_ok(dem_crc_ok),
  .synth_enable(synth_enable), .rf_rx_enable(rf_rx_enable),
  .gain_freeze(gain_freeze), .search_restart(search_restart));
`default_nettype wire

// ===== ssrx_sequencer_tb.sv
// Self-checking testbench of the receive sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module ssrx_sequencer_tb
  import ssrx_pkg::*;
;
  logic clk = 0, rst = 1, go = 0, go_wr = 0, done, seen = 0;
  logic [7:0] go_addr = 8'h00, adr;
  logic [31:0] go_data = 32'h0, rdata, wdat, rdat;
  logic rd, wr, wt, sy, se = 0, ps = 0, lk = 0, ho = 0, bv = 0, pe = 0;
  logic co = 0, rf, sr, gf;
  logic [7:0] bt = 8'h00;
  int error_cnt = 0, n_checks = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  ssrx_sequencer u_ssrx_sequencer (.clk(clk), .rst(rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wt),
    .dem_symbol_en(se), .dem_preamble_sym(ps), .dem_preamble_lock(lk),
    .dem_header_ok(ho), .dem_byte_valid(bv), .dem_byte(bt),
    .dem_payload_end(pe), .dem_crc_ok(co), .synth_enable(sy),
    .rf_rx_enable(rf), .gain_freeze(gf), .search_restart(sr));
  ssrx_host_model u_ssrx_host_model (.clk(clk), .rst(rst), .go(go),
    .go_wr(go_wr), .go_addr(go_addr), .go_data(go_data), .done(done),
    .rdata(rdata), .avm_address(adr), .avm_read(rd), .avm_write(wr),
    .avm_writedata(wdat), .avm_readdata(rdat), .avm_waitrequest(wt));
  always @(posedge clk) begin
    if (sr === 1'b1) seen = 1'b1;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic t1;
    @(posedge clk);
  endtask : t1
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    go <= 1'b1;
    go_wr <= w;
    go_addr <= a;
    go_data <= d;
    t1();
    go <= 1'b0;
    k = 0;
    do begin t1(); k++; end while (done !== 1'b1 && k < 40);
    if (done !== 1'b1) begin error_cnt++; complete_run(); end
  endtask : bus
  task automatic syms(input logic pre);
    ps <= pre;
    se <= 1'b1;
    t1();
    se <= 1'b0;
    repeat (3) t1();
  endtask : syms
  task automatic pkt(input int n, input logic crc, input logic [7:0] b0);
    lk <= 1'b1; t1(); lk <= 1'b0; t1();
    `CHK(gf, 1'b1)
    ho <= 1'b1; t1(); ho <= 1'b0; t1();
    for (int i = 0; i < n; i++) begin
      bv <= 1'b1; bt <= b0 + 8'(i); t1(); bv <= 1'b0; t1();
    end
    pe <= 1'b1; co <= crc; t1(); pe <= 1'b0; t1();
  endtask : pkt
  task automatic s_reset;
    bus(0, SSRX_ADDR_WINDOW, 0); `CHK(rdata[9:0], 10'h005)
    bus(0, SSRX_ADDR_BASES, 0); `CHK(rdata[15:0], 16'h8000)
    bus(0, SSRX_ADDR_DATA, 0); `CHK(rdata[7:0], 8'h00)
    bus(0, 8'h3c, 0); `CHK(rdata, 32'h0)
  endtask : s_reset
  task automatic s_cont;
    bus(1, SSRX_ADDR_MODE, SSRX_MODE_STANDBY);
    bus(1, SSRX_ADDR_PREAMBLE, 2);
    bus(1, SSRX_ADDR_HDRMODE, 1);
    bus(1, SSRX_ADDR_SYMDIV, 4);
    bus(1, SSRX_ADDR_TIMEOUT, 3);
    bus(1, SSRX_ADDR_MODE, SSRX_MODE_CONT);
    repeat (250) t1();
    bus(0, SSRX_ADDR_FLAGS, 0); `CHK(rdata[0], 1'b0)
    repeat (20) t1();
    bus(0, SSRX_ADDR_FLAGS, 0); `CHK(rdata[3:0], 4'h1)
    `CHK(rf, 1'b1)
    bus(1, SSRX_ADDR_FLAGS, 1);
    repeat (3) syms(1);
    t1();
    `CHK(seen, 1'b1)
    bus(0, SSRX_ADDR_FLAGS, 0); `CHK(rdata[3:0], 4'h0)
    pkt(2, 1, 8'h10);
    pkt(2, 1, 8'h20);
    `CHK(rf, 1'b1)
    bus(0, SSRX_ADDR_RXSTAT, 0); `CHK(rdata[23:0], 24'h040202)
    bus(0, SSRX_ADDR_FLAGS, 0); `CHK(rdata[3:0], 4'ha)
    bus(1, SSRX_ADDR_PTR, 0);
    for (int i = 0; i < 4; i++) begin
      bus(0, SSRX_ADDR_DATA, 0);
      `CHK(rdata[7:0], (i < 2) ? 8'h10 + 8'(i) : 8'h1e + 8'(i))
    end
    bus(1, SSRX_ADDR_FLAGS, 32'hf);
    bus(1, SSRX_ADDR_MODE, SSRX_MODE_STANDBY);
  endtask : s_cont
  task automatic s_single;
    bus(1, SSRX_ADDR_HDRMODE, 0);
    bus(1, SSRX_ADDR_TIMEOUT, 0);
    bus(1, SSRX_ADDR_PTR, 0);
    bus(1, SSRX_ADDR_MODE, SSRX_MODE_SINGLE);
    repeat (260) t1();
    pkt(3, 0, 8'h50);
    t1();
    `CHK(rf, 1'b0)
    `CHK(sy, 1'b0)
    bus(0, SSRX_ADDR_FLAGS, 0); `CHK(rdata[3:0], 4'he)
    bus(0, SSRX_ADDR_RXSTAT, 0); `CHK(rdata[23:0], 24'h030300)
    bus(1, SSRX_ADDR_PTR, 0);
    for (int i = 0; i < 3; i++) begin
      bus(0, SSRX_ADDR_DATA, 0); `CHK(rdata[7:0], 8'h50 + 8'(i))
    end
    bus(1, SSRX_ADDR_PTR, 32'h80);
    bus(1, SSRX_ADDR_DATA, 32'h71);
    bus(1, SSRX_ADDR_DATA, 32'h72);
    bus(1, SSRX_ADDR_PTR, 32'h80);
    for (int i = 1; i < 3; i++) begin
      bus(0, SSRX_ADDR_DATA, 0); `CHK(rdata[7:0], 8'h70 + 8'(i))
    end
    bus(1, SSRX_ADDR_FLAGS, 32'hf);
  endtask : s_single
  task automatic s_window;
    int k;
    bus(1, SSRX_ADDR_TIMEOUT, 0);
    bus(1, SSRX_ADDR_WINDOW, 4);
    bus(1, SSRX_ADDR_MODE, SSRX_MODE_SINGLE);
    k = 0;
    while (rf !== 1'b0 && k < 200) begin syms(0); k++; end
    `CHK(rf, 1'b0)
    bus(0, SSRX_ADDR_FLAGS, 0); `CHK(rdata[1:0], 2'b01)
    bus(1, SSRX_ADDR_PTR, 0);
    bus(0, SSRX_ADDR_DATA, 0); `CHK(rdata[7:0], 8'h00)
  endtask : s_window
  initial begin
    repeat (8) t1();
    rst <= 1'b0;
    t1();
    s_reset();
    s_cont();
    s_single();
    s_window();
    complete_run();
  end
endmodule : ssrx_sequencer_tb
`default_nettype wire
